//--- logic/qdcp_pkg.sv
// Package of the quad converter command decoder: frame fields, load
// control codes, output modes, decoder states and reset values.
// Assumes a 24-bit frame, most significant bit first.
package qdcp_pkg;

   // ------------------------------------------------------------
   // Frame layout
   // ------------------------------------------------------------
   localparam int FRAME_BITS = 24;
   localparam int CODE_BITS = 16;
   localparam int CHANNELS = 4;
   localparam int FIFO_DEPTH = 32;
   localparam int POS_ADDR_HI = 23;
   localparam int POS_ADDR_LO = 22;
   localparam int POS_LD_HI = 21;
   localparam int POS_LD_LO = 20;
   localparam int POS_SPARE = 19;
   localparam int POS_SEL_HI = 18;
   localparam int POS_SEL_LO = 17;
   localparam int POS_BCAST_WRITE = 18;
   localparam int POS_PD = 16;
   localparam int POS_MODE_HI = 15;
   localparam int POS_MODE_LO = 14;

   // ------------------------------------------------------------
   // Codes and reset values
   // ------------------------------------------------------------
   localparam logic [1:0] LD_BUFFER = 2'h0;
   localparam logic [1:0] LD_SINGLE = 2'h1;
   localparam logic [1:0] LD_ALL = 2'h2;
   localparam logic [1:0] LD_BCAST = 2'h3;
   localparam logic [15:0] CODE_RESET = 16'h0000;

   typedef enum logic [1:0]
   {
      MODE_NORMAL = 2'h0,
      MODE_1K = 2'h1,
      MODE_100K = 2'h2,
      MODE_HIZ = 2'h3
   } qdcp_mode_e;

   typedef enum logic [1:0]
   {
      ST_WAIT = 2'b01,
      ST_EXEC = 2'b10
   } qdcp_state_e;

endpackage

//--- logic/qdcp_word_if.sv
// Interface carrying a received frame from the serial-clock side to
// the system-clock side. Word is stable while toggle stands still.
`timescale 1ns/1ps
`default_nettype none
interface qdcp_word_if;
   logic [23:0] word;
   logic toggle;
   modport link (output word, output toggle);
   modport core (input word, input toggle);
endinterface
`default_nettype wire

//--- logic/qdcp_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two.
`timescale 1ns/1ps
`default_nettype none
module qdcp_fifo
#(
   parameter int WIDTH = 24,
   parameter int DEPTH = 32
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic [AW:0] next_wr_ptr;
   logic [AW:0] next_rd_ptr;
   logic push;
   logic pop;

   // ------------------------------------------------------------
   // Flags and pointers
   // ------------------------------------------------------------
   always_comb
   begin
      in_ready = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
      out_valid = wr_ptr != rd_ptr;
      out_data = mem[rd_ptr[AW-1:0]];
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
      if (push)
         mem[wr_ptr[AW-1:0]] <= in_data;
   end
endmodule
`default_nettype wire

//--- logic/qdcp_link_rx.sv
// Serial receiver on the link clock: shifts data on falling edges and
// hands each complete 24-bit frame over with a toggle.
// Assumes the link clock may stop between frames.
`timescale 1ns/1ps
`default_nettype none
module qdcp_link_rx
(
   input wire logic sclk,
   input wire logic clear,
   input wire logic frame_sync_n,
   input wire logic din,
   input wire logic enable_n,
   qdcp_word_if.link lk
);
   logic [4:0] bit_cnt;
   logic [4:0] next_bit_cnt;
   logic [22:0] shreg;
   logic [22:0] next_shreg;
   logic [23:0] next_word;
   logic next_toggle;
   logic frame_clr;

   // ------------------------------------------------------------
   // Shift and count
   // ------------------------------------------------------------
   // Sync high aborts frame
   assign frame_clr = clear | frame_sync_n;

   always_comb
   begin
      next_bit_cnt = bit_cnt;
      next_shreg = shreg;
      next_word = lk.word;
      next_toggle = lk.toggle;
      if (enable_n)
         next_bit_cnt = '0;
      else if (bit_cnt < 5'(qdcp_pkg::FRAME_BITS))
      begin
         next_shreg = {shreg[21:0], din};
         next_bit_cnt = bit_cnt + 5'h01;
         if (bit_cnt == 5'(qdcp_pkg::FRAME_BITS - 1))
         begin
            next_word = {shreg, din};
            next_toggle = ~lk.toggle;
         end
      end
   end

   // Counter cleared by frame sync itself, since the clock may stop
   always_ff @(negedge sclk or posedge frame_clr)
   begin
      if (frame_clr)
      begin
         bit_cnt <= '0;
         shreg <= '0;
      end
      else
      begin
         bit_cnt <= next_bit_cnt;
         shreg <= next_shreg;
      end
   end

   always_ff @(negedge sclk or posedge clear)
   begin
      if (clear)
      begin
         lk.word <= '0;
         lk.toggle <= 1'b0;
      end
      else
      begin
         lk.word <= next_word;
         lk.toggle <= next_toggle;
      end
   end
endmodule
`default_nettype wire

//--- logic/qdcp_core.sv
// Quad converter command decoder: serial frame capture, buffering,
// channel buffers, channel registers and per-channel output modes.
// Assumes straps and load trigger are asynchronous board pins.
//
// Overview of operation
// - While enable_n is high all serial activity is ignored.
// - The channel mode comes from frame bit 16 and bits 15 and 14.
// - Flag 0 is normal; 101 is 1k, 110 is 100k, 111 is high impedance.
// - Mode words travel the same buffer and load paths as data words.
// - Each channel keeps its own mode and data storage.
// - Power-down leaves the stored channel code untouched.
// - Load bits 00 write only the selected buffer.
// - Load bits 10 write the buffer then load all channels together.
// - Load bits 01 write the buffer and load only that channel.
// - Bits 18 and 17 select channel A, B, C or D.
// - Frame sync rising before the 24th edge discards the frame.
// - A rising edge on the load trigger loads all channels.
// - All channel registers hold zero after reset.
`timescale 1ns/1ps
`default_nettype none
module qdcp_core
#(
   parameter int CHANNELS = qdcp_pkg::CHANNELS,
   parameter int FIFO_DEPTH = qdcp_pkg::FIFO_DEPTH
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic sclk,
   input wire logic frame_sync_n,
   input wire logic din,
   input wire logic enable_n,
   input wire logic package_addr_bit0,
   input wire logic package_addr_bit1,
   input wire logic async_load_trigger,
   input wire logic apply_hold,
   output logic [CHANNELS*16-1:0] chan_code,
   output logic [CHANNELS*2-1:0] chan_mode,
   output logic word_dropped,
   output logic busy
);
   localparam int FB = qdcp_pkg::FRAME_BITS;

   qdcp_word_if lk ();

   qdcp_pkg::qdcp_state_e state;
   qdcp_pkg::qdcp_state_e next_state;
   logic [FB-1:0] cmd;
   logic [FB-1:0] next_cmd;
   logic [15:0] buf_code [CHANNELS];
   logic [15:0] next_buf_code [CHANNELS];
   qdcp_pkg::qdcp_mode_e buf_mode [CHANNELS];
   qdcp_pkg::qdcp_mode_e next_buf_mode [CHANNELS];
   logic [15:0] reg_code [CHANNELS];
   logic [15:0] next_reg_code [CHANNELS];
   qdcp_pkg::qdcp_mode_e reg_mode [CHANNELS];
   qdcp_pkg::qdcp_mode_e next_reg_mode [CHANNELS];
   logic link_clear;
   logic tog_s1;
   logic tog_s2;
   logic tog_s3;
   logic ldt_s1;
   logic ldt_s2;
   logic ldt_s3;
   logic [1:0] addr_s1;
   logic [1:0] addr_s2;
   logic next_link_clear;
   logic next_tog_s1;
   logic next_tog_s2;
   logic next_tog_s3;
   logic next_ldt_s1;
   logic next_ldt_s2;
   logic next_ldt_s3;
   logic [1:0] next_addr_s1;
   logic [1:0] next_addr_s2;
   logic frame_new;
   logic load_edge;
   logic next_word_dropped;
   logic fifo_ready;
   logic fifo_valid;
   logic fifo_pop;
   logic [FB-1:0] fifo_data;

   // ------------------------------------------------------------
   // Field decoding
   // ------------------------------------------------------------
   // Mode from flag and selects
   function automatic qdcp_pkg::qdcp_mode_e mode_of(logic [23:0] w);
      if (!w[qdcp_pkg::POS_PD])
         return qdcp_pkg::MODE_NORMAL;
      return qdcp_pkg::qdcp_mode_e'(
         w[qdcp_pkg::POS_MODE_HI:qdcp_pkg::POS_MODE_LO]);
   endfunction

   // Flag set with selects 00 is not a channel command here
   function automatic logic chan_cmd(logic [23:0] w);
      return !(w[qdcp_pkg::POS_PD] &&
         w[qdcp_pkg::POS_MODE_HI:qdcp_pkg::POS_MODE_LO] == 2'h0);
   endfunction

   // ------------------------------------------------------------
   // Link side and crossing
   // ------------------------------------------------------------
   qdcp_link_rx u_rx
   (
      .sclk(sclk),
      .clear(link_clear),
      .frame_sync_n(frame_sync_n),
      .din(din),
      .enable_n(enable_n),
      .lk(lk.link)
   );

   // Word is stable long before its toggle is seen here
   assign frame_new = tog_s2 ^ tog_s3;
   assign load_edge = ldt_s2 & ~ldt_s3;

   // Crossing chains are pure wiring; only the second flop reads the first
   always_comb
   begin
      next_link_clear = 1'b0;
      next_tog_s1 = lk.toggle;
      next_tog_s2 = tog_s1;
      next_tog_s3 = tog_s2;
      next_ldt_s1 = async_load_trigger;
      next_ldt_s2 = ldt_s1;
      next_ldt_s3 = ldt_s2;
      next_addr_s1 = {package_addr_bit1, package_addr_bit0};
      next_addr_s2 = addr_s1;
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         link_clear <= 1'b1;
         tog_s1 <= 1'b0;
         tog_s2 <= 1'b0;
         tog_s3 <= 1'b0;
         ldt_s1 <= 1'b0;
         ldt_s2 <= 1'b0;
         ldt_s3 <= 1'b0;
         addr_s1 <= 2'h0;
         addr_s2 <= 2'h0;
      end
      else
      begin
         link_clear <= next_link_clear;
         tog_s1 <= next_tog_s1;
         tog_s2 <= next_tog_s2;
         tog_s3 <= next_tog_s3;
         ldt_s1 <= next_ldt_s1;
         ldt_s2 <= next_ldt_s2;
         ldt_s3 <= next_ldt_s3;
         addr_s1 <= next_addr_s1;
         addr_s2 <= next_addr_s2;
      end
   end

   // ------------------------------------------------------------
   // Frame buffer
   // ------------------------------------------------------------
   // A frame that finds the buffer full is lost and flagged
   qdcp_fifo #(.WIDTH(FB), .DEPTH(FIFO_DEPTH)) u_fifo
   (
      .clock(clock),
      .rst(rst),
      .in_valid(frame_new),
      .in_ready(fifo_ready),
      .in_data(lk.word),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );

   assign fifo_pop = (state == qdcp_pkg::ST_WAIT) && !apply_hold;
   assign next_word_dropped = frame_new && !fifo_ready;
   assign busy = (state == qdcp_pkg::ST_EXEC) || fifo_valid;

   // ------------------------------------------------------------
   // Command execution
   // ------------------------------------------------------------
   always_comb
   begin
      logic [1:0] ld;
      logic [1:0] sel;
      logic load_all;
      logic load_one;
      logic write_all;
      logic write_one;
      ld = cmd[qdcp_pkg::POS_LD_HI:qdcp_pkg::POS_LD_LO];
      sel = cmd[qdcp_pkg::POS_SEL_HI:qdcp_pkg::POS_SEL_LO];
      load_all = 1'b0;
      load_one = 1'b0;
      write_all = 1'b0;
      write_one = 1'b0;
      next_state = state;
      next_cmd = cmd;
      next_buf_code = buf_code;
      next_buf_mode = buf_mode;
      next_reg_code = reg_code;
      next_reg_mode = reg_mode;
      case (state)
         qdcp_pkg::ST_WAIT:
         begin
            if (fifo_valid && fifo_pop)
            begin
               next_cmd = fifo_data;
               next_state = qdcp_pkg::ST_EXEC;
            end
         end
         qdcp_pkg::ST_EXEC:
         begin
            next_state = qdcp_pkg::ST_WAIT;
            if (ld == qdcp_pkg::LD_BCAST)
            begin
               // Broadcast ignores the package address
               load_all = 1'b1;
               write_all = cmd[qdcp_pkg::POS_BCAST_WRITE] && chan_cmd(cmd);
            end
            else if (cmd[qdcp_pkg::POS_ADDR_HI:qdcp_pkg::POS_ADDR_LO]
               == addr_s2 && chan_cmd(cmd))
            begin
               write_one = 1'b1;
               load_one = ld == qdcp_pkg::LD_SINGLE;
               load_all = ld == qdcp_pkg::LD_ALL;
            end
         end
         default:
         begin
            next_state = qdcp_pkg::ST_WAIT;
         end
      endcase
      // Mode words use the data path
      for (int i = 0; i < CHANNELS; i++)
      begin
         if (write_all || (write_one && sel == 2'(i)))
         begin
            next_buf_mode[i] = mode_of(cmd);
            if (!cmd[qdcp_pkg::POS_PD])
               next_buf_code[i] = cmd[qdcp_pkg::CODE_BITS-1:0];
         end
      end
      for (int i = 0; i < CHANNELS; i++)
      begin
         if (load_all || load_edge || (load_one && sel == 2'(i)))
         begin
            next_reg_code[i] = next_buf_code[i];
            next_reg_mode[i] = next_buf_mode[i];
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         state <= qdcp_pkg::ST_WAIT;
         cmd <= '0;
         word_dropped <= 1'b0;
         for (int i = 0; i < CHANNELS; i++)
         begin
            buf_code[i] <= qdcp_pkg::CODE_RESET;
            buf_mode[i] <= qdcp_pkg::MODE_NORMAL;
            reg_code[i] <= qdcp_pkg::CODE_RESET;
            reg_mode[i] <= qdcp_pkg::MODE_NORMAL;
         end
      end
      else
      begin
         state <= next_state;
         cmd <= next_cmd;
         word_dropped <= next_word_dropped;
         buf_code <= next_buf_code;
         buf_mode <= next_buf_mode;
         reg_code <= next_reg_code;
         reg_mode <= next_reg_mode;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   always_comb
   begin
      for (int i = 0; i < CHANNELS; i++)
      begin
         chan_code[i*16 +: 16] = reg_code[i];
         chan_mode[i*2 +: 2] = reg_mode[i];
      end
   end
endmodule
`default_nettype wire

//--- testbench/qdcp_core_properties.sv
// Port checker for the command decoder.
// Assumes it is bound to every qdcp_core instance.
`timescale 1ns/1ps
`default_nettype none
module qdcp_core_properties
#(
   parameter int CHANNELS = 4
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic sclk,
   input wire logic frame_sync_n,
   input wire logic din,
   input wire logic enable_n,
   input wire logic package_addr_bit0,
   input wire logic package_addr_bit1,
   input wire logic async_load_trigger,
   input wire logic apply_hold,
   input wire logic [CHANNELS*16-1:0] chan_code,
   input wire logic [CHANNELS*2-1:0] chan_mode,
   input wire logic word_dropped,
   input wire logic busy
);
   // ----
   // Helper counters
   // ----
   logic trig_q;
   logic [3:0] trig_age;
   logic [6:0] en_age;
   // Ages saturate so an old trigger edge never excuses a change
   always_ff @(posedge clock)
   begin
      trig_q <= async_load_trigger;
      if (rst || (async_load_trigger && !trig_q))
         trig_age <= 4'h0;
      else if (trig_age != 4'hF)
         trig_age <= trig_age + 4'h1;
      if (rst || !enable_n)
         en_age <= 7'h00;
      else if (en_age != 7'h7F)
         en_age <= en_age + 7'h01;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // ----
   // Properties
   // ----
   sequence s_drop_tail;
      !word_dropped [*8];
   endsequence
   sequence s_quiet;
      (!busy && !word_dropped) [*3];
   endsequence
   property p_rst_zero;
      $fell(rst) |-> chan_code == '0 && chan_mode == '0;
   endproperty
   property p_rst_quiet;
      $fell(rst) |-> s_quiet;
   endproperty
   property p_code_cause;
      $changed(chan_code) |-> $past(busy) || trig_age <= 4'h8;
   endproperty
   property p_mode_cause;
      $changed(chan_mode) |-> $past(busy) || trig_age <= 4'h8;
   endproperty
   property p_drop_pulse;
      word_dropped |=> s_drop_tail;
   endproperty
   property p_drop_full;
      word_dropped |-> busy;
   endproperty
   property p_enable_quiet;
      (en_age == 7'h7F && !apply_hold) |-> !busy;
   endproperty
   property p_busy_drain;
      (busy && !apply_hold) |-> ##[1:200] !busy;
   endproperty
   a_rst_zero: assert property (p_rst_zero)
      else $error("channels not zero after reset");
   a_rst_quiet: assert property (p_rst_quiet)
      else $error("activity right after reset");
   a_code_cause: assert property (p_code_cause)
      else $error("code changed without command or trigger");
   a_mode_cause: assert property (p_mode_cause)
      else $error("mode changed without command or trigger");
   a_drop_pulse: assert property (p_drop_pulse)
      else $error("drop flag longer than one cycle");
   a_drop_full: assert property (p_drop_full)
      else $error("drop flag while buffer empty");
   a_enable_quiet: assert property (p_enable_quiet)
      else $error("work done while disabled");
   a_busy_drain: assert property (p_busy_drain)
      else $error("busy never cleared");
endmodule
bind qdcp_core qdcp_core_properties #(.CHANNELS(CHANNELS)) i_qdcp_props (
   .clock(clock), .rst(rst), .sclk(sclk), .frame_sync_n(frame_sync_n),
   .din(din), .enable_n(enable_n), .package_addr_bit0(package_addr_bit0),
   .package_addr_bit1(package_addr_bit1),
   .async_load_trigger(async_load_trigger), .apply_hold(apply_hold),
   .chan_code(chan_code), .chan_mode(chan_mode),
   .word_dropped(word_dropped), .busy(busy));
`default_nettype wire

//--- testbench/qdcp_host_model.sv
// Host serial master: sends frames of up to 24 bits, MSB first.
// Assumes the decoder samples data on falling link clock edges.
`timescale 1ns/1ps
`default_nettype none
module qdcp_host_model
(
   output logic sclk,
   output logic frame_sync_n,
   output logic din
);
   initial
   begin
      sclk = 1'b1;
      frame_sync_n = 1'b1;
      din = 1'b0;
   end
   // caller gives strap bits, spare zero
   // Clock stands still between frames; odd start keeps phase loose
   task automatic send(input logic [23:0] w, input int nbits);
      #37.1 frame_sync_n = 1'b0;
      for (int i = 0; i < nbits; i++)
      begin
         din = w[23-i];
         #80 sclk = 1'b0;
         #80 sclk = 1'b1;
      end
      #80 frame_sync_n = 1'b1;
      din = ~din;
      #160;
   endtask
endmodule
`default_nettype wire

//--- testbench/qdcp_core_tb_top.sv
// Self-checking bench of the command decoder with a host model.
// Assumes a four-entry frame buffer to keep the fill test short.
`timescale 1ns/1ps
`default_nettype none
module qdcp_core_tb_top;
   localparam logic [1:0] STRAP = 2'h2;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic enable_n = 1'b0;
   logic async_load_trigger = 1'b0;
   logic apply_hold = 1'b0;
   wire logic sclk;
   wire logic frame_sync_n;
   wire logic din;
   logic [63:0] chan_code;
   logic [7:0] chan_mode;
   logic word_dropped;
   logic busy;
   logic [15:0] bc [4];
   logic [15:0] rc [4];
   logic [1:0] bm [4];
   logic [1:0] rm [4];
   logic [23:0] w;
   int num_errors = 0;
   int checks = 0;
   int drops = 0;
   int seed;
   always #2 clock = ~clock;
   always @(negedge clock)
      if (word_dropped === 1'b1)
         drops++;
   qdcp_host_model i_qdcp_host_model (.sclk(sclk),
      .frame_sync_n(frame_sync_n), .din(din));
   qdcp_core #(.FIFO_DEPTH(4)) i_qdcp_core (.clock(clock), .rst(rst),
      .sclk(sclk), .frame_sync_n(frame_sync_n), .din(din),
      .enable_n(enable_n), .package_addr_bit0(STRAP[0]),
      .package_addr_bit1(STRAP[1]),
      .async_load_trigger(async_load_trigger), .apply_hold(apply_hold),
      .chan_code(chan_code), .chan_mode(chan_mode),
      .word_dropped(word_dropped), .busy(busy));
   // ----
   // Expectation model
   // ----
   function automatic void clear_model();
      for (int i = 0; i < 4; i++)
      begin
         bc[i] = 16'h0000;
         rc[i] = 16'h0000;
         bm[i] = 2'h0;
         rm[i] = 2'h0;
      end
   endfunction
   function automatic void load_all();
      rc = bc;
      rm = bm;
   endfunction
   function automatic void model(input logic [23:0] f);
      logic [1:0] ld;
      int ch;
      ld = f[21:20];
      ch = f[18:17];
      if (ld != qdcp_pkg::LD_BCAST && f[23:22] != STRAP)
         return;
      if (ld == qdcp_pkg::LD_BCAST && !f[18])
      begin
         load_all();
         return;
      end
      if (f[16] && f[15:14] == 2'h0)
      begin
         if (ld == qdcp_pkg::LD_BCAST)
            load_all();
         return;
      end
      for (int i = 0; i < 4; i++)
         if (i == ch || ld == qdcp_pkg::LD_BCAST)
         begin
            bm[i] = f[16] ? f[15:14] : 2'h0;
            if (!f[16])
               bc[i] = f[15:0];
         end
      if (ld == qdcp_pkg::LD_SINGLE)
      begin
         rc[ch] = bc[ch];
         rm[ch] = bm[ch];
      end
      else if (ld != qdcp_pkg::LD_BUFFER)
         load_all();
   endfunction
   function automatic logic [23:0] mk(input logic [1:0] ld,
      input logic [1:0] ch, input logic pd, input logic [15:0] v);
      return {STRAP, ld, 1'b0, ch, pd, v};
   endfunction
   // ----
   // Checks and drivers
   // ----
   task automatic finish_test();
      if (num_errors == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic check_code(input logic [15:0] got, input logic [15:0] e);
      checks++;
      if (got !== e)
      begin
         num_errors++;
         $display("[FAIL] %0t code %h exp %h", $time, got, e);
      end
   endtask
   task automatic check_mode(input logic [1:0] got, input logic [1:0] e);
      checks++;
      if (got !== e)
      begin
         num_errors++;
         $display("[FAIL] %0t mode %h exp %h", $time, got, e);
      end
   endtask
   task automatic check_flag(input logic got, input logic e);
      checks++;
      if (got !== e)
      begin
         num_errors++;
         $display("[FAIL] %0t flag %h exp %h", $time, got, e);
      end
   endtask
   task automatic check_all();
      for (int i = 0; i < 4; i++)
      begin
         check_code(chan_code[i*16+:16], rc[i]);
         check_mode(chan_mode[i*2+:2], rm[i]);
      end
   endtask
   task automatic settle();
      int n;
      n = 0;
      repeat (8) @(negedge clock);
      while (busy !== 1'b0 && n < 300)
      begin
         @(negedge clock);
         n++;
      end
      if (busy !== 1'b0)
      begin
         num_errors++;
         finish_test();
      end
   endtask
   task automatic frame(input logic [23:0] f);
      i_qdcp_host_model.send(f, 24);
      model(f);
      settle();
      check_all();
   endtask
   // ----
   // Scenarios
   // ----
   initial
   begin
      clear_model();
      seed = $urandom(32'h06C66475);
      repeat (4) @(posedge clock);
      @(negedge clock) rst = 1'b0;
      repeat (3) @(negedge clock);
      check_all();
      for (int k = 0; k < 14; k++)
      begin
         w = 24'($urandom);
         w[19] = 1'b0;
         if ($urandom_range(3) != 0)
            w[23:22] = STRAP;
         frame(w);
      end
      for (int m = 1; m < 4; m++)
         frame(mk(qdcp_pkg::LD_SINGLE, m[1:0], 1'b1, {m[1:0], 14'h0}));
      frame(mk(qdcp_pkg::LD_BCAST, 2'h2, 1'b1, 16'hC000));
      frame(mk(qdcp_pkg::LD_BUFFER, 2'h1, 1'b0, 16'hBEEF));
      frame(mk(qdcp_pkg::LD_BCAST, 2'h0, 1'b0, 16'h0000));
      w = mk(qdcp_pkg::LD_SINGLE, 2'h3, 1'b0, 16'h0F0F);
      w[23:22] = ~STRAP;
      frame(w);
      w = mk(qdcp_pkg::LD_SINGLE, 2'h0, 1'b0, 16'h1234);
      i_qdcp_host_model.send(w, 23);
      settle();
      check_all();
      enable_n = 1'b1;
      i_qdcp_host_model.send(mk(qdcp_pkg::LD_ALL, 2'h1, 1'b0, 16'h4321), 24);
      @(negedge clock) enable_n = 1'b0;
      settle();
      check_all();
      apply_hold = 1'b1;
      for (int c = 0; c < 4; c++)
      begin
         w = mk(qdcp_pkg::LD_BUFFER, c[1:0], 1'b0, 16'(($urandom)));
         i_qdcp_host_model.send(w, 24);
         model(w);
      end
      i_qdcp_host_model.send(mk(qdcp_pkg::LD_ALL, 2'h0, 1'b0, 16'hFFFF), 24);
      repeat (8) @(negedge clock);
      check_flag(busy, 1'b1);
      apply_hold = 1'b0;
      settle();
      check_all();
      check_flag(drops == 1, 1'b1);
      async_load_trigger = 1'b1;
      repeat (8) @(negedge clock);
      async_load_trigger = 1'b0;
      load_all();
      check_all();
      rst = 1'b1;
      repeat (2) @(negedge clock);
      rst = 1'b0;
      clear_model();
      repeat (3) @(negedge clock);
      check_all();
      finish_test();
   end
endmodule
`default_nettype wire
